// ### fpm_pkg.sv
// ----------------------------------------------------------------
// shared constants of the framer performance monitor
// ----------------------------------------------------------------
package fpm_pkg;
  // bus widths
  localparam int ADDR_W = 8;               // framer-local register address
  localparam int DATA_W = 8;               // byte-wide register data

  // counter widths
  localparam int BIT_ERR_W  = 12;          // bit error event counter
  localparam int FRM_ERR_W  = 9;           // framing bit error counter
  localparam int OOF_W      = 5;           // out of frame counter
  localparam int ALIGN_W    = 3;           // alignment change counter
  localparam int FRAME_CNT_W = 14;         // frames between auto latches

  // register offsets
  localparam logic [7:0] IRQ_ENABLE_OFS  = 8'h40; // enable, same layout as status
  localparam logic [7:0] IRQ_CLEAR_OFS   = 8'h41; // write one to clear status bits
  localparam logic [7:0] CONFIG_OFS      = 8'h42; // auto latch, format, valid
  localparam logic [7:0] STATUS_OFS      = 8'h49; // enable bit, transfer, overrun
  localparam logic [7:0] BIT_ERR_LO_OFS  = 8'h4a;
  localparam logic [7:0] BIT_ERR_HI_OFS  = 8'h4b;
  localparam logic [7:0] FRM_ERR_LO_OFS  = 8'h4c;
  localparam logic [7:0] FRM_ERR_HI_OFS  = 8'h4d;
  localparam logic [7:0] OOF_OFS         = 8'h4e;
  localparam logic [7:0] ALIGN_OFS       = 8'h4f;

  // field positions
  localparam int ST_OVR_BIT   = 0;         // overrun flag
  localparam int ST_TRANSFER_DONE_FLAG_BIT  = 1;         // transfer done flag
  localparam int ST_TRANSFER_IRQ_ENABLE_BIT  = 2;         // transfer irq enable alias
  localparam int CFG_AUTO_BIT = 0;         // auto latch enable
  localparam int CFG_ESF_BIT  = 1;         // extended superframe format
  localparam int CFG_VALID_BIT = 7;        // holding registers valid, read only

  // values after reset
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  localparam logic       AUTO_RST   = 1'b0;
  localparam logic       ESF_RST    = 1'b0;

  // timing
  localparam int FRAMES_PER_UPDATE = 8000;  // frames between automatic latches
  localparam int CLK_PERIOD_NS     = 40;    // core clock period
  localparam int READ_WAIT_NS      = 2300;  // software wait after a latch write
  localparam int READ_WAIT_CYC     = (READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_CYC         = 2;     // write edge to holding update, in edges
endpackage

// ### fpm_counters.sv
`timescale 1ns/1ps
// What this block does
// - any count register write latches all counters
// - global update latches every framer together
// - auto latch once every 8000 frames
// - copy then clear counters, losing no event
// - holding updated within 3.5 line clocks
// - holding undefined until first transfer
// - reads return held, not live, counts
// - bit error counter 12 bits, split 8/4
// - bit errors: crc-6 in esf, framing in sf
// - framing error counter 9 bits, split 8/1
// - out of frame counter 5 bits
// - alignment change counter 3 bits
// - transfer flag set per transfer, read clears
// - overrun when unacknowledged transfer overwritten
// - transfer raises interrupt when enabled
module fpm_counters
  import fpm_pkg::*;
#(
  parameter int FRAMES_PER_UPDATE_P = fpm_pkg::FRAMES_PER_UPDATE
)
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic [fpm_pkg::ADDR_W-1:0] addr,
  input  wire logic [fpm_pkg::DATA_W-1:0] wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [fpm_pkg::DATA_W-1:0] rd_data,
  output logic                           irq,
  input  wire logic                      global_update,
  input  wire logic                      frame_pulse,
  input  wire logic                      crc6_error,
  input  wire logic                      framing_bit_error,
  input  wire logic                      out_of_frame_event,
  input  wire logic                      alignment_change_event
);
  import fpm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BIT_ERR_W-1:0]   bit_error_event_count;     // live counters
    logic [FRM_ERR_W-1:0]   framing_bit_error_count;
    logic [OOF_W-1:0]       out_of_frame_count;
    logic [ALIGN_W-1:0]     frame_alignment_change_count;
    logic [BIT_ERR_W-1:0]   bit_err_hold;              // holding copies
    logic [FRM_ERR_W-1:0]   frm_err_hold;
    logic [OOF_W-1:0]       oof_hold;
    logic [ALIGN_W-1:0]     align_hold;
    logic                   pending;                   // merged latch request
    logic                   hold_valid;                // first transfer done
    logic                   transfer_done_flag;
    logic                   holding_overrun_flag;
    logic [1:0]             irq_en;                    // {transfer_done_flag, ovr}
    logic                   auto_latch_enable;
    logic                   extended_superframe_format;
    logic [FRAME_CNT_W-1:0] frame_cnt;                 // frames since auto latch
    logic [DATA_W-1:0]      rd_data;
    logic                   irq;
  } fpm_state_t;

  fpm_state_t st;                                      // registered state
  fpm_state_t next_st;                                 // next state

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic count_wr;                                      // write to a count location
  logic status_rd;                                     // read of the status register
  logic auto_req;                                      // auto latch frame reached
  logic bit_err_inc;                                   // bit error event this cycle

  // any of the six count locations latches the whole group
  assign count_wr    = wr_en && (addr >= BIT_ERR_LO_OFS) && (addr <= ALIGN_OFS);
  assign status_rd   = rd_en && (addr == STATUS_OFS);
  assign auto_req    = st.auto_latch_enable && frame_pulse
                       && (st.frame_cnt == FRAME_CNT_W'(FRAMES_PER_UPDATE_P - 1));
  // format select picks the event that counts as a bit error
  assign bit_err_inc = st.extended_superframe_format ? crc6_error : framing_bit_error;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rd_data = '0;

    // a request only marks pending; the transfer is one cycle later so that
    // several sources in one interval collapse into a single copy
    if (count_wr || global_update || auto_req)
    begin
      next_st.pending = 1'b1;
    end

    // frame counter for the automatic update
    if (!st.auto_latch_enable)
    begin
      next_st.frame_cnt = '0;                          // restart when disabled
    end
    else if (frame_pulse)
    begin
      next_st.frame_cnt = auto_req ? '0 : st.frame_cnt + FRAME_CNT_W'(1);
    end

    if (st.pending)
    begin
      // copy, then restart counters with this cycle's event so none is lost
      next_st.bit_err_hold = st.bit_error_event_count;
      next_st.frm_err_hold = st.framing_bit_error_count;
      next_st.oof_hold     = st.out_of_frame_count;
      next_st.align_hold   = st.frame_alignment_change_count;
      next_st.bit_error_event_count        = BIT_ERR_W'(bit_err_inc);
      next_st.framing_bit_error_count      = FRM_ERR_W'(framing_bit_error);
      next_st.out_of_frame_count           = OOF_W'(out_of_frame_event);
      next_st.frame_alignment_change_count = ALIGN_W'(alignment_change_event);
      next_st.hold_valid   = 1'b1;
      next_st.pending      = count_wr || global_update || auto_req;
    end
    else
    begin
      // saturating counts; wrapping would hide a burst as a small number
      if (bit_err_inc && (st.bit_error_event_count != '1))
      begin
        next_st.bit_error_event_count = st.bit_error_event_count + BIT_ERR_W'(1);
      end
      if (framing_bit_error && (st.framing_bit_error_count != '1))
      begin
        next_st.framing_bit_error_count = st.framing_bit_error_count + FRM_ERR_W'(1);
      end
      if (out_of_frame_event && (st.out_of_frame_count != '1))
      begin
        next_st.out_of_frame_count = st.out_of_frame_count + OOF_W'(1);
      end
      if (alignment_change_event && (st.frame_alignment_change_count != '1))
      begin
        next_st.frame_alignment_change_count = st.frame_alignment_change_count + ALIGN_W'(1);
      end
    end

    // status clears on read or by the clear register; a transfer wins
    if (status_rd)
    begin
      next_st.transfer_done_flag   = 1'b0;
      next_st.holding_overrun_flag = 1'b0;
    end
    if (wr_en && (addr == IRQ_CLEAR_OFS))
    begin
      if (wr_data[ST_TRANSFER_DONE_FLAG_BIT])
      begin
        next_st.transfer_done_flag = 1'b0;
      end
      if (wr_data[ST_OVR_BIT])
      begin
        next_st.holding_overrun_flag = 1'b0;
      end
    end
    if (st.pending)
    begin
      next_st.transfer_done_flag = 1'b1;
      // previous transfer still unacknowledged: holding overwritten
      if (st.transfer_done_flag && !status_rd)
      begin
        next_st.holding_overrun_flag = 1'b1;
      end
    end

    // control register writes
    if (wr_en)
    begin
      unique case (addr)
        IRQ_ENABLE_OFS:
        begin
          next_st.irq_en = wr_data[1:0];
        end
        STATUS_OFS:
        begin
          next_st.irq_en[ST_TRANSFER_DONE_FLAG_BIT] = wr_data[ST_TRANSFER_IRQ_ENABLE_BIT];
        end
        CONFIG_OFS:
        begin
          next_st.auto_latch_enable          = wr_data[CFG_AUTO_BIT];
          next_st.extended_superframe_format = wr_data[CFG_ESF_BIT];
        end
        default:
        begin
          // count locations only latch; others are ignored
        end
      endcase
    end

    // read mux: held values only, never the live counters
    if (rd_en)
    begin
      unique case (addr)
        BIT_ERR_LO_OFS: next_st.rd_data = st.bit_err_hold[7:0];
        BIT_ERR_HI_OFS: next_st.rd_data = {4'h0, st.bit_err_hold[11:8]};
        FRM_ERR_LO_OFS: next_st.rd_data = st.frm_err_hold[7:0];
        FRM_ERR_HI_OFS: next_st.rd_data = {7'h00, st.frm_err_hold[8]};
        OOF_OFS:        next_st.rd_data = {3'h0, st.oof_hold};
        ALIGN_OFS:      next_st.rd_data = {5'h00, st.align_hold};
        STATUS_OFS:     next_st.rd_data = {5'h00, st.irq_en[ST_TRANSFER_DONE_FLAG_BIT],
                                           st.transfer_done_flag, st.holding_overrun_flag};
        IRQ_ENABLE_OFS: next_st.rd_data = {6'h00, st.irq_en};
        CONFIG_OFS:     next_st.rd_data = {st.hold_valid, 5'h00,
                                           st.extended_superframe_format, st.auto_latch_enable};
        default:        next_st.rd_data = '0;           // unmapped reads as zero
      endcase
    end

    // level interrupt from the flags about to be stored
    next_st.irq = |({next_st.transfer_done_flag, next_st.holding_overrun_flag}
                    & next_st.irq_en);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // holding values reset to zero only for determinism; the valid bit says
  // whether software may trust them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st                            <= '0;
      st.irq_en                     <= IRQ_EN_RST;
      st.auto_latch_enable          <= AUTO_RST;
      st.extended_superframe_format <= ESF_RST;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign irq     = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  property p_local_latch;
    count_wr |-> ##LATCH_CYC st.hold_valid && st.transfer_done_flag;
  endproperty
  a_local_latch: assert property (p_local_latch) else $error("count write did not latch");

  property p_global;
    global_update |=> st.pending ##1 st.transfer_done_flag;
  endproperty
  a_global: assert property (p_global) else $error("global update did not transfer");

  property p_auto;
    auto_req |=> st.pending && (st.frame_cnt == '0);
  endproperty
  a_auto: assert property (p_auto) else $error("auto latch missing");

  property p_copy;
    st.pending |=> (st.bit_err_hold == $past(st.bit_error_event_count))
                   && (st.oof_hold == $past(st.out_of_frame_count));
  endproperty
  a_copy: assert property (p_copy) else $error("holding copy wrong");

  property p_restart;
    st.pending && !alignment_change_event |=> st.frame_alignment_change_count == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not cleared on transfer");

  property p_read;
    rd_en && (addr == BIT_ERR_HI_OFS) |=> rd_data == {4'h0, $past(st.bit_err_hold[11:8])};
  endproperty
  a_read: assert property (p_read) else $error("bit error high read wrong");

  property p_bit_err;
    !st.pending && st.extended_superframe_format && crc6_error && !framing_bit_error
      && (st.bit_error_event_count != '1)
      |=> (st.bit_error_event_count == $past(st.bit_error_event_count) + 12'h001)
          && (st.framing_bit_error_count == $past(st.framing_bit_error_count));
  endproperty
  a_bit_err: assert property (p_bit_err) else $error("crc error not counted");

  property p_sat;
    !st.pending && (st.out_of_frame_count == '1) |=> st.out_of_frame_count == '1;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");

  property p_read_clear;
    status_rd && !st.pending |=> !st.transfer_done_flag && !st.holding_overrun_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

  property p_ovr;
    st.pending && st.transfer_done_flag && !status_rd |=> st.holding_overrun_flag;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_irq;
    st.transfer_done_flag && st.irq_en[ST_TRANSFER_DONE_FLAG_BIT] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("transfer interrupt missing");

  // ----------------------------------------------------------------
  // checks on masking, format select, read-back and merging
  // ----------------------------------------------------------------
  // no enable, no interrupt, whatever the flags say
  property p_irq_off;
    (st.irq_en == 2'h0) |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");

  // standard superframe: each framing bit error is also a bit error event
  property p_sf_bit_err;
    !st.pending && !st.extended_superframe_format && framing_bit_error
      && (st.bit_error_event_count != '1) && (st.framing_bit_error_count != '1)
      |=> (st.bit_error_event_count == $past(st.bit_error_event_count) + 12'h001)
          && (st.framing_bit_error_count == $past(st.framing_bit_error_count) + 9'h001);
  endproperty
  a_sf_bit_err: assert property (p_sf_bit_err) else $error("framing error not counted as bit error");

  // upper framing bit comes from the held copy, never the live count
  property p_frm_read;
    rd_en && (addr == FRM_ERR_HI_OFS) |=> rd_data == {7'h00, $past(st.frm_err_hold[8])};
  endproperty
  a_frm_read: assert property (p_frm_read) else $error("framing error high read wrong");

  // out of frame count reads back in the low five bits
  property p_oof_read;
    rd_en && (addr == OOF_OFS) |=> rd_data == {3'h0, $past(st.oof_hold)};
  endproperty
  a_oof_read: assert property (p_oof_read) else $error("out of frame read wrong");

  // a quiet transfer cycle ends pending, so merged requests copy once
  property p_merge;
    st.pending && !count_wr && !global_update && !auto_req |=> !st.pending;
  endproperty
  a_merge: assert property (p_merge) else $error("merged requests copied twice");

  c_merge:   cover property (count_wr && global_update);
  c_overrun: cover property (st.pending && st.transfer_done_flag);
  c_auto:    cover property (auto_req);
  c_esf_crc: cover property (st.extended_superframe_format && crc6_error && !st.pending);
endmodule

// ### fpm_event_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// behavioural receive framer: event detectors and frame pulses
// ----------------------------------------------------------------
module fpm_event_model
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,                  // load a new burst
  input  wire logic [4:0] sel,                    // {frame, align, oof, framing, crc6}
  input  wire logic [8:0] count,                  // pulses on each selected line
  input  wire logic       slow,                   // one pulse every other cycle
  output logic            busy,                   // burst still running
  output logic            crc6_error,
  output logic            framing_bit_error,
  output logic            out_of_frame_event,
  output logic            alignment_change_event,
  output logic            frame_pulse
);
  logic [8:0] left;                               // pulses still to send
  logic [4:0] lines;                              // lines of this burst
  logic [4:0] pulses;                             // registered pulse outputs
  logic       gap;                                // idle cycle in slow mode

  // pulses leave a register so they never glitch around the edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      left   <= 9'h000;
      lines  <= 5'h00;
      pulses <= 5'h00;
      gap    <= 1'b0;
    end
    else if (start)
    begin
      left   <= count;
      lines  <= sel;
      pulses <= 5'h00;
      gap    <= 1'b0;
    end
    else if (left != 9'h000 && !gap)
    begin
      pulses <= lines;                            // one event per high cycle
      left   <= left - 9'h001;
      gap    <= slow;
    end
    else
    begin
      pulses <= 5'h00;
      gap    <= 1'b0;
    end
  end

  assign {frame_pulse, alignment_change_event, out_of_frame_event, framing_bit_error, crc6_error} = pulses;
  assign busy = (left != 9'h000);
endmodule

// ### tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench of the performance monitor
// ----------------------------------------------------------------
module tb;
  import fpm_pkg::*;
  logic              core_clk, rst, clk_en, wr_en, rd_en, irq, global_update;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, va, vb;
  logic              frame_pulse, crc6_error, framing_bit_error, out_of_frame_event, alignment_change_event;
  logic              ev_start, ev_slow, ev_busy;
  logic [4:0]        ev_sel;
  logic [8:0]        ev_count;
  int                bad_count, total_checks, cycles;

  // short auto interval keeps the run brief
  fpm_counters #(.FRAMES_PER_UPDATE_P(4)) fpm_counters_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .global_update(global_update), .frame_pulse(frame_pulse), .crc6_error(crc6_error),
    .framing_bit_error(framing_bit_error), .out_of_frame_event(out_of_frame_event),
    .alignment_change_event(alignment_change_event));
  fpm_event_model fpm_event_model_i (.core_clk(core_clk), .rst(rst), .start(ev_start), .sel(ev_sel),
    .count(ev_count), .slow(ev_slow), .busy(ev_busy), .crc6_error(crc6_error),
    .framing_bit_error(framing_bit_error), .out_of_frame_event(out_of_frame_event),
    .alignment_change_event(alignment_change_event), .frame_pulse(frame_pulse));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // whole sequence needs well under 3000 cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // events from the far side, waits for the last pulse
  task automatic burst(input logic [4:0] s, input logic [8:0] n, input logic sl);
    @(posedge core_clk);
    ev_start <= 1'b1;
    ev_sel   <= s;
    ev_count <= n;
    ev_slow  <= sl;
    @(posedge core_clk);
    ev_start <= 1'b0;
    #1;
    while (ev_busy)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1; addr = 8'h00; wr_data = 8'h00; wr_en = 1'b0; rd_en = 1'b0; global_update = 1'b0;
    ev_start = 1'b0; ev_sel = 5'h00; ev_count = 9'h000; ev_slow = 1'b0; clk_en = 1'b1;
    bad_count = 0; total_checks = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(STATUS_OFS, 8'h00);
    rd_chk(CONFIG_OFS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd_chk(8'h10, 8'h00);
    // sf: framing errors feed the bit error count, crc-6 ignored
    burst(5'h03, 9'd5, 1'b1);
    burst(5'h01, 9'd3, 1'b0);
    burst(5'h04, 9'd2, 1'b0);
    burst(5'h08, 9'd3, 1'b0);
    wr(OOF_OFS, 8'h00);
    repeat (READ_WAIT_CYC) @(posedge core_clk);
    rd_chk(BIT_ERR_LO_OFS, 8'h05);
    rd_chk(BIT_ERR_HI_OFS, 8'h00);
    rd_chk(FRM_ERR_LO_OFS, 8'h05);
    rd_chk(FRM_ERR_HI_OFS, 8'h00);
    rd_chk(OOF_OFS, 8'h02);
    rd_chk(ALIGN_OFS, 8'h03);
    rd_chk(CONFIG_OFS, 8'h80);
    rd_chk(STATUS_OFS, 8'h02);
    rd_chk(STATUS_OFS, 8'h00);
    // live counts move, holding does not
    burst(5'h04, 9'd4, 1'b0);
    rd_chk(OOF_OFS, 8'h02);
    // esf, wide counts and saturation, global latch
    wr(CONFIG_OFS, 8'h02);
    burst(5'h0f, 9'd300, 1'b0);
    @(posedge core_clk);
    global_update <= 1'b1;
    @(posedge core_clk);
    global_update <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd_chk(BIT_ERR_LO_OFS, 8'h2c);
    rd_chk(BIT_ERR_HI_OFS, 8'h01);
    rd_chk(FRM_ERR_LO_OFS, 8'h2c);
    rd_chk(FRM_ERR_HI_OFS, 8'h01);
    rd_chk(OOF_OFS, 8'h1f);
    rd_chk(ALIGN_OFS, 8'h07);
    rd_chk(STATUS_OFS, 8'h02);
    // interrupt raise, clear, overrun, mask
    wr(IRQ_ENABLE_OFS, 8'h02);
    wr(BIT_ERR_LO_OFS, 8'h00);
    @(posedge core_clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(IRQ_CLEAR_OFS, 8'h02);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr(IRQ_ENABLE_OFS, 8'h03);
    wr(BIT_ERR_HI_OFS, 8'h00);
    wr(FRM_ERR_LO_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    rd_chk(STATUS_OFS, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wr(IRQ_ENABLE_OFS, 8'h00);
    wr(FRM_ERR_HI_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, irq}, 8'h00);
    rd_chk(STATUS_OFS, 8'h02);
    // two sources in one cycle give one transfer, read at once
    burst(5'h08, 9'd2, 1'b0);
    @(posedge core_clk);
    addr          <= ALIGN_OFS;
    wr_en         <= 1'b1;
    global_update <= 1'b1;
    @(posedge core_clk);
    wr_en         <= 1'b0;
    global_update <= 1'b0;
    rd_chk(ALIGN_OFS, 8'h02);
    rd_chk(STATUS_OFS, 8'h02);
    // latch in mid-burst loses and doubles nothing
    fork
      burst(5'h04, 9'd20, 1'b1);
      begin
        repeat (15) @(posedge core_clk);
        wr(OOF_OFS, 8'h00);
      end
    join
    repeat (2) @(posedge core_clk);
    rd(OOF_OFS, va);
    wr(OOF_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    rd(OOF_OFS, vb);
    chk(va + vb, 8'h14);
    // automatic latch after the shortened frame count
    wr(CONFIG_OFS, 8'h03);
    rd(STATUS_OFS, va);
    burst(5'h10, 9'd3, 1'b0);
    repeat (2) @(posedge core_clk);
    rd_chk(STATUS_OFS, 8'h00);
    burst(5'h10, 9'd1, 1'b0);
    repeat (2) @(posedge core_clk);
    rd_chk(STATUS_OFS, 8'h02);
    // frozen clock enable: events and latch requests are ignored
    clk_en <= 1'b0;
    burst(5'h04, 9'd3, 1'b0);
    wr(OOF_OFS, 8'h00);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd_chk(STATUS_OFS, 8'h00);
    // esf: crc-6 alone counts as a bit error, not as a framing error
    burst(5'h01, 9'd2, 1'b0);
    wr(OOF_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    rd_chk(OOF_OFS, 8'h00);
    rd_chk(BIT_ERR_LO_OFS, 8'h02);
    rd_chk(FRM_ERR_LO_OFS, 8'h00);
    // overrun alone raises the interrupt, its clear bit drops it
    wr(IRQ_ENABLE_OFS, 8'h01);
    wr(ALIGN_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(IRQ_CLEAR_OFS, 8'h01);
    #1;
    chk({7'h00, irq}, 8'h00);
    rd_chk(STATUS_OFS, 8'h02);
    // enable alias in the status register
    wr(STATUS_OFS, 8'h04);
    rd_chk(IRQ_ENABLE_OFS, 8'h03);
    end_of_test();
  end
endmodule
